/* design/rx_front_pkg.sv */
// Package for the receive bit front end: register map, fields, timing.
// Assumes a 50 MHz system clock and an AXI4-Lite register bus.
package rx_front_pkg;
    // Register byte offsets
    localparam logic [7:0] off_receiver_status = 8'h00;
    localparam logic [7:0] off_receive_data_buffer = 8'h04;
    localparam logic [7:0] off_transmitter_status = 8'h08;
    localparam logic [7:0] off_function_inputs = 8'h0c;
    localparam logic [7:0] off_irq_status = 8'h10;
    localparam logic [7:0] off_irq_mask = 8'h14;
    localparam logic [7:0] off_ones_status = 8'h18;
    // Receiver status fields
    localparam int bit_receiver_enable = 4;
    localparam int bit_receive_abort = 5;
    localparam int bit_receiver_active = 11;
    // Receive data buffer fields
    localparam int bit_start_of_message = 8;
    // Transmitter status fields
    localparam int bit_half_duplex = 3;
    localparam int bit_send = 4;
    localparam int bit_maint_data = 10;
    localparam int bit_maint_select_a = 11;
    localparam int bit_maint_step_clock = 13;
    // Function input fields (next values of the three flags)
    localparam int bit_next_frame = 0;
    localparam int bit_next_receiver_active = 1;
    localparam int bit_next_message_active = 2;
    // Interrupt event bits
    localparam int irq_stuffed_zero = 0;
    localparam int irq_flag_char = 1;
    localparam int irq_abort_char = 2;
    localparam int irq_width = 3;
    // Reset values
    localparam logic [15:0] reset_control = 16'h0000;
    localparam logic [2:0] reset_mask = 3'h0;
    // Ones counts that mark stuffed zero, flag and abort
    localparam logic [3:0] ones_stuffed = 4'h5;
    localparam logic [3:0] ones_flag = 4'h6;
    localparam logic [3:0] ones_abort = 4'h8;
    // Strobe timing
    localparam int clk_period_ns = 20;
    localparam int strobe_ns = 250;
    localparam int delayed_strobe_ns = 70;
    localparam int strobe_cycles = strobe_ns / clk_period_ns;
    localparam int delayed_cycles = delayed_strobe_ns / clk_period_ns;
    localparam int strobe_total = strobe_cycles + delayed_cycles;
endpackage

/* design/rx_strobe_gen.sv */
// Derives bit strobes from the selected receive clock.
// Assumes a raw clock level already synchronised to aclk.
`timescale 1ns/1ns
module rx_strobe_gen (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic rx_clock_sync, // Synchronised selected clock
    strobe_if.source strobes // Strobe outputs
);
    typedef struct packed {
        logic prev;
        logic rising;
        logic [4:0] count;
    } gen_state_t;
    gen_state_t s_reg;
    gen_state_t s_next;

    // Edge detect and timed windows, single-cycle enables out
    always_comb begin
        s_next = s_reg;
        s_next.prev = rx_clock_sync;
        if (s_reg.count != 5'h00) begin
            s_next.count = s_reg.count - 5'h01;
        end
        if (rx_clock_sync != s_reg.prev) begin
            s_next.rising = rx_clock_sync;
            s_next.count = 5'(rx_front_pkg::strobe_total);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // First strobe at the edge; delayed strobe 12 cycles (240 ns) later, as 250 ns truncates to whole cycles
    logic first_pulse;
    logic delayed_pulse;
    assign first_pulse = (s_reg.count == 5'(rx_front_pkg::strobe_total));
    assign delayed_pulse = (s_reg.count == 5'(rx_front_pkg::delayed_cycles));
    assign strobes.bit_on_strobe = first_pulse && s_reg.rising;
    assign strobes.bit_off_strobe = first_pulse && !s_reg.rising;
    assign strobes.delayed_bit_on_strobe =
        delayed_pulse && s_reg.rising;
    assign strobes.late_end_of_bit_strobe =
        delayed_pulse && !s_reg.rising;
    assign strobes.sampled_clock = s_reg.prev;
endmodule

/* design/strobe_if.sv */
// Interface carrying per-bit strobes from the strobe generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface strobe_if;
    logic bit_on_strobe;
    logic bit_off_strobe;
    logic delayed_bit_on_strobe;
    logic late_end_of_bit_strobe;
    logic sampled_clock;
    modport source (output bit_on_strobe, output bit_off_strobe,
        output delayed_bit_on_strobe, output late_end_of_bit_strobe,
        output sampled_clock);
    modport sink (input bit_on_strobe, input bit_off_strobe,
        input delayed_bit_on_strobe, input late_end_of_bit_strobe,
        input sampled_clock);
endinterface

/* design/sync_rx_bit_front_end.sv */
// Receive bit front end of a bit-synchronous line interface.
// Assumes AXI4-Lite master on aclk; modem pins are asynchronous.
// Function
// - Latch three control flags on late strobe
// - Message flag drives start-of-message buffer bit
// - Receiver-active flag readable at status bit 11
// - Maintenance select A picks maintenance clock
// - Half duplex while sending blocks modem clock
// - Clock edges make 250 ns on/off strobes
// - Expiry makes 70 ns delayed strobe pair
// - Ones counter clears on zero at late strobe
// - Detect stuffed zero, flag, abort from count
// - Counter held until first zero sets latch
// - Enable latch holds until receiver clear
// - Latch and counter sample data on bit-on
// - Mark is one, idle line is marks
// - Serial input from line or maintenance OR transmit
// - Receiver clear while disabled or aborting
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module sync_rx_bit_front_end (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic modem_receive_clock, // Modem clock pin
    input wire logic modem_receive_data, // Modem data pin, mark high
    input wire logic internal_transmit_data, // Transmit serial bit
    output logic receiver_clear, // Clears downstream receive logic
    output logic [7:0] ones_run_counter, // Consecutive ones count
    output logic frame_flag, // Frame control flag
    output logic message_active_flag, // Message active flag
    output logic stuffed_zero_seen, // Five ones detected
    output logic flag_char_seen, // Six ones detected
    output logic abort_char_seen, // Eight or more ones detected
    output logic irq // Level interrupt
);
    ////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_write_resp = 2'b01,
        bus_read_resp = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] resp;
        logic [31:0] rdata;
        logic [15:0] receiver_status_reg;
        logic [15:0] transmitter_status_reg;
        logic [2:0] function_inputs;
        logic frame_flag;
        logic receiver_active_flag;
        logic message_active_flag;
        logic rx_start_of_message;
        logic ones_counter_enable_latch;
        logic [7:0] ones_run_counter;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [1:0] clk_sync;
        logic [1:0] data_sync;
    } front_state_t;

    front_state_t s_reg;
    front_state_t s_next;
    strobe_if strobes ();

    ////////////////////////////////////////////////////////////////
    // Clock and data selection
    logic half_duplex_select;
    logic send_bit;
    logic maint_select_a;
    logic maintenance_serial_in;
    logic maintenance_clock;
    logic selected_clock;
    logic rx_serial_in;
    logic receiver_enable_bit;
    logic receive_abort_bit;

    assign half_duplex_select =
        s_reg.transmitter_status_reg[rx_front_pkg::bit_half_duplex];
    assign send_bit = s_reg.transmitter_status_reg[rx_front_pkg::bit_send];
    assign maint_select_a =
        s_reg.transmitter_status_reg[rx_front_pkg::bit_maint_select_a];
    assign maintenance_serial_in =
        s_reg.transmitter_status_reg[rx_front_pkg::bit_maint_data];
    assign maintenance_clock =
        s_reg.transmitter_status_reg[rx_front_pkg::bit_maint_step_clock];
    assign receiver_enable_bit =
        s_reg.receiver_status_reg[rx_front_pkg::bit_receiver_enable];
    assign receive_abort_bit =
        s_reg.receiver_status_reg[rx_front_pkg::bit_receive_abort];

    // Pick the clock; block modem clock while sending half duplex
    assign selected_clock = maint_select_a ? maintenance_clock
        : (s_reg.clk_sync[1] & ~(half_duplex_select & send_bit));
    // Serial input: line data, or maintenance bit OR transmit data
    assign rx_serial_in = maint_select_a
        ? (maintenance_serial_in | internal_transmit_data)
        : s_reg.data_sync[1];
    // Receiver clear while disabled or aborting
    assign receiver_clear = ~receiver_enable_bit | receive_abort_bit;

    rx_strobe_gen rx_strobe_gen_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_clock_sync(selected_clock),
        .strobes(strobes)
    );

    ////////////////////////////////////////////////////////////////
    // Ones run decode
    logic [2:0] events;
    always_comb begin
        events = '0;
        events[rx_front_pkg::irq_stuffed_zero] =
            (s_reg.ones_run_counter == 8'(rx_front_pkg::ones_stuffed));
        events[rx_front_pkg::irq_flag_char] =
            (s_reg.ones_run_counter == 8'(rx_front_pkg::ones_flag));
        events[rx_front_pkg::irq_abort_char] =
            (s_reg.ones_run_counter >= 8'(rx_front_pkg::ones_abort));
    end
    // Bit-on strobe marks a new detection for the interrupt
    logic count_step;
    assign count_step = strobes.bit_on_strobe;

    ////////////////////////////////////////////////////////////////
    // Bus decode
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [31:0] read_word;
    logic read_hit;
    assign s_axi_awready = (s_reg.bus == bus_idle) && !s_reg.aw_held;
    assign s_axi_wready = (s_reg.bus == bus_idle) && !s_reg.w_held;
    assign s_axi_arready = (s_reg.bus == bus_idle) && !s_axi_awvalid
        && !s_reg.aw_held && !s_reg.w_held;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Read multiplexer
    always_comb begin
        read_word = '0;
        read_hit = 1'b1;
        case (s_axi_araddr)
            rx_front_pkg::off_receiver_status: begin
                read_word[15:0] = s_reg.receiver_status_reg;
                read_word[rx_front_pkg::bit_receiver_active] =
                    s_reg.receiver_active_flag;
            end
            rx_front_pkg::off_receive_data_buffer: begin
                read_word[rx_front_pkg::bit_start_of_message] =
                    s_reg.rx_start_of_message;
            end
            rx_front_pkg::off_transmitter_status: begin
                read_word[15:0] = s_reg.transmitter_status_reg;
            end
            rx_front_pkg::off_function_inputs: begin
                read_word[2:0] = s_reg.function_inputs;
            end
            rx_front_pkg::off_irq_status: read_word[2:0] = s_reg.irq_status;
            rx_front_pkg::off_irq_mask: read_word[2:0] = s_reg.irq_mask;
            rx_front_pkg::off_ones_status: begin
                read_word[7:0] = s_reg.ones_run_counter;
                read_word[8] = s_reg.ones_counter_enable_latch;
                read_word[9] = s_reg.frame_flag;
                read_word[10] = s_reg.message_active_flag;
            end
            default: read_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [15:0] wmask;
        logic write_now;
        logic [2:0] new_events;
        wmask = {{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
        write_now = 1'b0;
        new_events = '0;
        s_next = s_reg;
        s_next.clk_sync = {s_reg.clk_sync[0], modem_receive_clock};
        s_next.data_sync = {s_reg.data_sync[0], modem_receive_data};

        // Bus channels
        if (aw_take) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        case (s_reg.bus)
            bus_idle: begin
                if (s_reg.aw_held && s_reg.w_held) begin
                    write_now = 1'b1;
                    s_next.aw_held = 1'b0;
                    s_next.w_held = 1'b0;
                    s_next.bus = bus_write_resp;
                    s_next.resp = 2'b00;
                end else if (ar_take) begin
                    s_next.rdata = read_word;
                    s_next.resp = read_hit ? 2'b00 : 2'b10;
                    s_next.bus = bus_read_resp;
                end
            end
            bus_write_resp: if (s_axi_bready) s_next.bus = bus_idle;
            bus_read_resp: if (s_axi_rready) s_next.bus = bus_idle;
            default: s_next.bus = bus_idle;
        endcase

        // Register writes
        if (write_now) begin
            case (s_reg.aw_addr)
                rx_front_pkg::off_receiver_status:
                    s_next.receiver_status_reg =
                        (s_reg.receiver_status_reg & ~wmask)
                        | (s_reg.w_data[15:0] & wmask);
                rx_front_pkg::off_transmitter_status:
                    s_next.transmitter_status_reg =
                        (s_reg.transmitter_status_reg & ~wmask)
                        | (s_reg.w_data[15:0] & wmask);
                rx_front_pkg::off_function_inputs:
                    if (s_reg.w_strb[0]) s_next.function_inputs =
                        s_reg.w_data[2:0];
                rx_front_pkg::off_irq_mask:
                    if (s_reg.w_strb[0]) s_next.irq_mask = s_reg.w_data[2:0];
                default: s_next.resp = 2'b10;
            endcase
        end

        // Control flags latched once per bit on the late strobe
        if (strobes.late_end_of_bit_strobe) begin
            s_next.frame_flag =
                s_reg.function_inputs[rx_front_pkg::bit_next_frame];
            s_next.receiver_active_flag =
                s_reg.function_inputs[rx_front_pkg::bit_next_receiver_active];
            s_next.message_active_flag =
                s_reg.function_inputs[rx_front_pkg::bit_next_message_active];
        end
        s_next.rx_start_of_message = s_reg.message_active_flag;

        // Enable latch and ones counter sample on bit-on
        if (strobes.bit_on_strobe) begin
            if (!rx_serial_in) begin
                s_next.ones_counter_enable_latch = 1'b1;
            end
            if (s_reg.ones_counter_enable_latch && rx_serial_in) begin
                if (s_reg.ones_run_counter != 8'hff) begin
                    s_next.ones_run_counter =
                        s_reg.ones_run_counter + 8'h01;
                end
            end
        end
        // Zero present at late strobe clears the run
        if (strobes.late_end_of_bit_strobe && !rx_serial_in) begin
            s_next.ones_run_counter = '0;
        end
        if (!s_reg.ones_counter_enable_latch) begin
            s_next.ones_run_counter = '0;
        end
        if (receiver_clear) begin
            s_next.ones_counter_enable_latch = 1'b0;
            s_next.ones_run_counter = '0;
        end

        // Sticky events; a read clears but a new event wins
        new_events = (count_step && s_reg.ones_counter_enable_latch)
            ? events : 3'h0;
        if (ar_take && s_reg.bus == bus_idle && !(s_reg.aw_held
            && s_reg.w_held) && s_axi_araddr == rx_front_pkg::off_irq_status)
        begin
            s_next.irq_status = new_events;
        end else begin
            s_next.irq_status = s_reg.irq_status | new_events;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.bus <= bus_idle;
            s_reg.receiver_status_reg <= rx_front_pkg::reset_control;
            s_reg.transmitter_status_reg <= rx_front_pkg::reset_control;
            s_reg.irq_mask <= rx_front_pkg::reset_mask;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_bvalid = (s_reg.bus == bus_write_resp);
    assign s_axi_bresp = s_reg.resp;
    assign s_axi_rvalid = (s_reg.bus == bus_read_resp);
    assign s_axi_rresp = s_reg.resp;
    assign s_axi_rdata = s_reg.rdata;
    assign ones_run_counter = s_reg.ones_run_counter;
    assign frame_flag = s_reg.frame_flag;
    assign message_active_flag = s_reg.message_active_flag;
    assign stuffed_zero_seen = events[rx_front_pkg::irq_stuffed_zero];
    assign flag_char_seen = events[rx_front_pkg::irq_flag_char];
    assign abort_char_seen = events[rx_front_pkg::irq_abort_char];
    assign irq = |(s_reg.irq_status & s_reg.irq_mask);
endmodule

/* tb/modem_model.sv */
// Behavioural modem driving receive clock and data.
// Assumes the bench calls send_bits; clock stands still between frames.
`timescale 1ns/1ns
module modem_model (
    output logic rx_clock, // Line clock, low outside frames
    output logic rx_data // Line data, mark is high
);
    // Idle line holds marks
    initial begin
        rx_clock = 1'b0;
        rx_data = 1'b1;
    end
    // Data moves in the low phase, well clear of both strobes
    task automatic send_bits(input logic [15:0] b, input int k,
            input int h);
        for (int i = 0; i < k; i++) begin
            #(h * 3 / 4) rx_data <= b[i];
            #(h / 4) rx_clock <= 1'b1;
            #(h) rx_clock <= 1'b0;
        end
        #(h * 3 / 4) rx_data <= 1'b1;
    endtask
endmodule

/* tb/sync_rx_bit_front_end_assertions.sv */
// Port checker for the receive bit front end.
// Assumes it is bound to the top module on aclk.
`timescale 1ns/1ns
module rx_front_checker (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Reset, low
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic receiver_clear, // Receiver clear
    input wire logic [7:0] ones_run_counter, // Ones count
    input wire logic stuffed_zero_seen, // Five ones
    input wire logic flag_char_seen, // Six ones
    input wire logic abort_char_seen // Eight or more ones
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Decodes follow the count exactly
    a_stuffed_decode: assert property (
        stuffed_zero_seen == (ones_run_counter == 8'h05))
        else $error("stuffed zero decode wrong");
    a_flag_decode: assert property (
        flag_char_seen == (ones_run_counter == 8'h06))
        else $error("flag decode wrong");
    a_abort_decode: assert property (
        abort_char_seen == (ones_run_counter >= 8'h08))
        else $error("abort decode wrong");
    // Count only steps up by one or drops to zero
    a_count_step: assert property ($changed(ones_run_counter) |->
        ones_run_counter == 8'h00 ||
        ones_run_counter == $past(ones_run_counter) + 8'h01)
        else $error("ones count jumped");
    // One strobe per edge: no two steps in a row
    a_single_step: assert property (
        $changed(ones_run_counter) && ones_run_counter != 8'h00 |=>
        $stable(ones_run_counter) || ones_run_counter == 8'h00)
        else $error("ones count stepped twice");
    a_clear_holds: assert property (
        receiver_clear [*3] |-> ones_run_counter == 8'h00)
        else $error("count not held by receiver clear");
    // Responses stand until taken
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_stuffed: cover property (stuffed_zero_seen);
    c_flag: cover property (flag_char_seen);
    c_abort: cover property (abort_char_seen);
endmodule
bind sync_rx_bit_front_end rx_front_checker rx_front_checker_inst (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .receiver_clear,
    .ones_run_counter, .stuffed_zero_seen, .flag_char_seen,
    .abort_char_seen);

/* tb/sync_rx_bit_front_end_tb.sv */
// Self-checking bench for the receive bit front end.
// Assumes the modem model drives the line and the checker is bound.
`timescale 1ns/1ns
module sync_rx_bit_front_end_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, internal_transmit_data;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, receiver_clear, frame_flag, message_active_flag;
    logic stuffed_zero_seen, flag_char_seen, abort_char_seen, irq;
    logic modem_receive_clock, modem_receive_data;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ones_run_counter;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] ev, m;
    int n_errors, n_checks, n;
    int ns_tab[4] = '{5, 6, 8, 14};
    sync_rx_bit_front_end sync_rx_bit_front_end_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .modem_receive_clock, .modem_receive_data,
        .internal_transmit_data, .receiver_clear, .ones_run_counter,
        .frame_flag, .message_active_flag, .stuffed_zero_seen,
        .flag_char_seen, .abort_char_seen, .irq);
    modem_model modem_model_inst (.rx_clock(modem_receive_clock),
        .rx_data(modem_receive_data));
    // 50 MHz clock
    always #10 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic ck(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic w(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Write; each channel released at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    // Read; data taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (1) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic bits(input logic [15:0] b, input int k, input int h);
        modem_model_inst.send_bits(b, k, h);
        w(4);
    endtask
    // Software clock step: low, high, low with select A set
    task automatic mstep(input logic b);
        for (int k = 0; k < 3; k++) begin
            wr(8'h08, {18'h0, k == 1, 2'h1, b, 10'h0});
            w(30);
        end
    endtask
    function automatic logic [2:0] events_for(input int k);
        return {k >= 8, k >= 6, k >= 5};
    endfunction
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, internal_transmit_data} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        w(20);
        aresetn <= 1'b1;
        void'($urandom(73));
        w(1);
        ck("receiver_clear", 1, receiver_clear);
        rd(8'h00);
        ck("status", 0, d);
        rd(8'h1c);
        ck("unmapped resp", 2, r);
        ck("unmapped data", 0, d);
        wr(8'h18, 32'h0);
        ck("read-only resp", 2, r);
        wr(8'h00, 32'h10);
        ck("receiver_clear", 0, receiver_clear);
        bits(16'h000f, 4, 80);
        ck("idle count", 0, ones_run_counter);
        $display("test reset and idle done");
        for (int i = 0; i < 8; i++) begin
            n = (i < 4) ? ns_tab[i] : 1 + $urandom % 13;
            m = 3'($urandom);
            wr(8'h14, {29'h0, m});
            rd(8'h14);
            ck("mask", m, d);
            bits(16'(((1 << n) - 1) << 1), n + 1, 480);
            ck("ones count", n, ones_run_counter);
            ck("stuffed", n == 5, stuffed_zero_seen);
            ck("flag", n == 6, flag_char_seen);
            ck("abort", n >= 8, abort_char_seen);
            bits(16'h0, 1, 480);
            ck("cleared count", 0, ones_run_counter);
            ev = events_for(n);
            ck("irq", |(ev & m), irq);
            rd(8'h10);
            ck("events", ev, d);
            ck("irq cleared", 0, irq);
        end
        $display("test ones runs done");
        wr(8'h0c, 32'h7);
        bits(16'h0, 1, 480);
        ck("frame", 1, frame_flag);
        ck("message", 1, message_active_flag);
        rd(8'h00);
        ck("active", 1, d[11]);
        rd(8'h04);
        ck("start of message", 1, d[8]);
        rd(8'h18);
        ck("ones status", 32'h700, d);
        wr(8'h0c, 32'h0);
        bits(16'h0, 1, 480);
        ck("frame", 0, frame_flag);
        ck("message", 0, message_active_flag);
        $display("test flags done");
        wr(8'h08, 32'h18);
        bits(16'h7, 3, 480);
        ck("blocked count", 0, ones_run_counter);
        mstep(1'b0);
        mstep(1'b1);
        mstep(1'b1);
        internal_transmit_data <= 1'b1;
        mstep(1'b0);
        ck("maint count", 3, ones_run_counter);
        bits(16'h0, 1, 480);
        ck("modem ignored", 3, ones_run_counter);
        wr(8'h00, 32'h30);
        w(4);
        ck("abort clear", 0, ones_run_counter);
        ck("receiver_clear", 1, receiver_clear);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h10);
        bits(16'h7, 3, 480);
        ck("latch cleared", 0, ones_run_counter);
        $display("test duplex and maintenance done");
        close_out();
    end
endmodule
